// ---- pla_params.svh ----
// offsets, reset values, limits and timing for the loop processor
`ifndef PLA_PARAMS_SVH
`define PLA_PARAMS_SVH
`define PLA_OFS_MODE 8'h00
`define PLA_OFS_GAIN 8'h04
`define PLA_OFS_ITIME 8'h08
`define PLA_OFS_DTIME 8'h0C
`define PLA_OFS_FILT 8'h10
`define PLA_OFS_BAND 8'h14
`define PLA_OFS_KIND 8'h18
`define PLA_OFS_UPPER 8'h1C
`define PLA_OFS_LOWER 8'h20
`define PLA_OFS_CMD 8'h24
`define PLA_OFS_CTRL 8'h28
`define PLA_OFS_STAT 8'h2C
`define PLA_OFS_MASK 8'h30
`define PLA_OFS_MV 8'h34
`define PLA_OFS_FB 8'h38
`define PLA_MAX_GAIN 16'h7530
`define PLA_MAX_ITIME 16'h8CA0
`define PLA_MAX_DTIME 16'hEA60
`define PLA_MAX_FILT 16'h2328
`define PLA_MAX_BAND 16'h07D0
`define PLA_RST_GAIN 16'h03E8
`define PLA_RST_UPPER 16'h03E8
`define PLA_RST_LOWER 16'h0000
`define PLA_CTRL_CLEAR 0
`define PLA_CTRL_INVERT 1
`define PLA_ST_TRIP 0
`define PLA_ST_WIND 1
`define PLA_GAIN_UNIT 1000
`define PLA_FRAC 16
`define PLA_CLK_MHZ 200
`define PLA_SAMPLE_US 1000
`define PLA_SAMPLE_CYC (`PLA_SAMPLE_US * `PLA_CLK_MHZ)
`define PLA_TENTH_S_US 100000
`define PLA_HUNDREDTH_S_US 10000
`define PLA_TENTH_PER_TS (`PLA_TENTH_S_US / `PLA_SAMPLE_US)
`define PLA_TS_PER_HUNDREDTH (`PLA_HUNDREDTH_S_US / `PLA_SAMPLE_US)
`endif

// ---- pla_pkg.sv ----
// types shared by the loop processor
package pla_pkg;
  typedef enum logic [1:0] {
    PLA_OFF,
    PLA_NORMAL,
    PLA_INVERSE
  } pla_mode_e;
  typedef struct packed {
    pla_mode_e loop_mode_select;
    logic [15:0] proportional_gain_setting;
    logic [15:0] integral_time_setting;
    logic [15:0] differential_time_setting;
    logic [15:0] feedback_filter_time;
    logic [15:0] windup_band_setting;
    logic [2:0] trip_kind_select;
    logic [15:0] upper_trip_bound_setting;
    logic [15:0] lower_trip_bound_setting;
    logic [15:0] process_command_value;
    logic invert;
  } pla_cfg_s;
endpackage

// ---- pla_loop.sv ----
// loop processor with feedback filter, windup hold and trip output
// Operation
// - integral accumulates deviation into output
// - differential time 0..600.00 s
// - zero differential time removes D term
// - D term is time derivative times setting
// - feedback filter 0..900.0 s time constant
// - integrator frozen outside windup band
// - windup band 0..200.0 percent
// - trip kinds: 0-3 absolute, 4-7 deviation
// - absolute trip: below lower or above upper
// - deviation trip: outside command minus/plus bounds
// - hold: trip waits for leave and re-entry
// - latch: trip stays until fault clear
// - bounds are percent of feedback full scale
// - inverted absolute trip shows in-range
// - integral time 0..3600.0 s, zero disables
// - gain 0..30.000 scales the deviation
// - mode: 0 off, 1 normal, 2 inverse
//
// Our own choices: the APB slave port and the register addresses.
`include "pla_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pla_loop #(
  parameter int SAMPLE_CYC = `PLA_SAMPLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [15:0] i_measured_feedback,
  output logic [31:0] o_manipulated_frequency,
  output logic o_loop_trip_output,
  output logic o_irq
);
  pla_pkg::pla_cfg_s cfg, next_cfg;
  logic [1:0] stat, next_stat, mask, next_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, wr, fclear;
  logic [31:0] cnt, next_cnt;
  logic tick;
  logic signed [47:0] fy, next_fy, acc, next_acc, dterm, next_dterm;
  logic signed [47:0] fbx, sum;
  logic signed [63:0] prod;
  logic signed [31:0] next_mv;
  logic signed [17:0] fbf, e, e_prev, next_e_prev, ae;
  logic wind, wind_q, next_wind_q;
  logic signed [18:0] cmdx, lox, hix, fbw;
  logic in_trip, armed, next_armed, latched, next_latched, raw, trip;
  logic trip_q, next_trip_q, next_out;

  function automatic logic [15:0] clamp(input logic [31:0] v,
                                        input logic [15:0] m);
    clamp = (v > {16'h0000, m}) ? m : v[15:0];
  endfunction

  // one wait state so read data can come from a flop
  assign wr = i_psel & i_penable & o_pready & i_pwrite;
  assign fclear = wr && i_paddr == `PLA_OFS_CTRL &&
                  i_pwdata[`PLA_CTRL_CLEAR];

  always_comb begin
    next_cfg = cfg;
    next_mask = mask;
    next_pready = i_psel & i_penable & ~o_pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (i_paddr == `PLA_OFS_MODE) begin
      next_prdata = {30'h0, cfg.loop_mode_select};
    end else if (i_paddr == `PLA_OFS_GAIN) begin
      next_prdata = {16'h0, cfg.proportional_gain_setting};
    end else if (i_paddr == `PLA_OFS_ITIME) begin
      next_prdata = {16'h0, cfg.integral_time_setting};
    end else if (i_paddr == `PLA_OFS_DTIME) begin
      next_prdata = {16'h0, cfg.differential_time_setting};
    end else if (i_paddr == `PLA_OFS_FILT) begin
      next_prdata = {16'h0, cfg.feedback_filter_time};
    end else if (i_paddr == `PLA_OFS_BAND) begin
      next_prdata = {16'h0, cfg.windup_band_setting};
    end else if (i_paddr == `PLA_OFS_KIND) begin
      next_prdata = {29'h0, cfg.trip_kind_select};
    end else if (i_paddr == `PLA_OFS_UPPER) begin
      next_prdata = {16'h0, cfg.upper_trip_bound_setting};
    end else if (i_paddr == `PLA_OFS_LOWER) begin
      next_prdata = {16'h0, cfg.lower_trip_bound_setting};
    end else if (i_paddr == `PLA_OFS_CMD) begin
      next_prdata = {16'h0, cfg.process_command_value};
    end else if (i_paddr == `PLA_OFS_CTRL) begin
      next_prdata = {30'h0, cfg.invert, 1'b0};
    end else if (i_paddr == `PLA_OFS_STAT) begin
      next_prdata = {30'h0, stat};
    end else if (i_paddr == `PLA_OFS_MASK) begin
      next_prdata = {30'h0, mask};
    end else if (i_paddr == `PLA_OFS_MV) begin
      next_prdata = o_manipulated_frequency;
    end else if (i_paddr == `PLA_OFS_FB) begin
      next_prdata = {{14{fbf[17]}}, fbf};
    end else begin
      next_pslverr = next_pready;
    end
    if (wr) begin
      if (i_paddr == `PLA_OFS_MODE) begin
        // unused code 3 falls back to off
        next_cfg.loop_mode_select = (i_pwdata[1:0] == 2'h3) ?
          pla_pkg::PLA_OFF : pla_pkg::pla_mode_e'(i_pwdata[1:0]);
      end else if (i_paddr == `PLA_OFS_GAIN) begin
        next_cfg.proportional_gain_setting =
          clamp(i_pwdata, `PLA_MAX_GAIN);
      end else if (i_paddr == `PLA_OFS_ITIME) begin
        next_cfg.integral_time_setting =
          clamp(i_pwdata, `PLA_MAX_ITIME);
      end else if (i_paddr == `PLA_OFS_DTIME) begin
        next_cfg.differential_time_setting =
          clamp(i_pwdata, `PLA_MAX_DTIME);
      end else if (i_paddr == `PLA_OFS_FILT) begin
        next_cfg.feedback_filter_time =
          clamp(i_pwdata, `PLA_MAX_FILT);
      end else if (i_paddr == `PLA_OFS_BAND) begin
        next_cfg.windup_band_setting =
          clamp(i_pwdata, `PLA_MAX_BAND);
      end else if (i_paddr == `PLA_OFS_KIND) begin
        next_cfg.trip_kind_select = i_pwdata[2:0];
      end else if (i_paddr == `PLA_OFS_UPPER) begin
        next_cfg.upper_trip_bound_setting = i_pwdata[15:0];
      end else if (i_paddr == `PLA_OFS_LOWER) begin
        next_cfg.lower_trip_bound_setting = i_pwdata[15:0];
      end else if (i_paddr == `PLA_OFS_CMD) begin
        next_cfg.process_command_value = i_pwdata[15:0];
      end else if (i_paddr == `PLA_OFS_CTRL) begin
        next_cfg.invert = i_pwdata[`PLA_CTRL_INVERT];
      end else if (i_paddr == `PLA_OFS_MASK) begin
        next_mask = i_pwdata[1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg <= '{loop_mode_select: pla_pkg::PLA_OFF,
               proportional_gain_setting: `PLA_RST_GAIN,
               upper_trip_bound_setting: `PLA_RST_UPPER,
               lower_trip_bound_setting: `PLA_RST_LOWER,
               default: '0};
      mask <= 2'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      mask <= next_mask;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
      o_prdata <= next_prdata;
    end
  end

  // loop math runs once per sample period
  assign tick = (cnt == 32'(SAMPLE_CYC - 1));
  assign fbx = $signed({16'h0000, i_measured_feedback, 16'h0000});
  assign fbf = fy[33:16];
  assign e = (cfg.loop_mode_select == pla_pkg::PLA_INVERSE) ?
             fbf - $signed({2'b00, cfg.process_command_value}) :
             $signed({2'b00, cfg.process_command_value}) - fbf;
  assign ae = e[17] ? -e : e;
  assign wind = ae > $signed({2'b00, cfg.windup_band_setting});
  assign sum = (48'(e) <<< `PLA_FRAC) + acc +
               (dterm <<< `PLA_FRAC);
  assign prod = 64'(sum) * $signed({48'h0, cfg.proportional_gain_setting});

  always_comb begin
    next_cnt = tick ? 32'h0000_0000 : cnt + 32'h0000_0001;
    next_fy = fy;
    next_acc = acc;
    next_dterm = dterm;
    next_e_prev = e_prev;
    next_wind_q = wind_q;
    next_mv = o_manipulated_frequency;
    if (tick) begin
      if (cfg.feedback_filter_time == 16'h0000) begin
        next_fy = fbx;
      end else begin
        next_fy = fy + (fbx - fy) / ($signed({32'h0,
          cfg.feedback_filter_time}) * 48'(`PLA_TENTH_PER_TS));
      end
      next_e_prev = e;
      next_wind_q = wind;
      if (cfg.loop_mode_select == pla_pkg::PLA_OFF ||
          cfg.integral_time_setting == 16'h0000) begin
        next_acc = '0;
      end else if (!wind) begin
        next_acc = acc + (48'(e) <<< `PLA_FRAC) /
          ($signed({32'h0, cfg.integral_time_setting}) *
           48'(`PLA_TENTH_PER_TS));
      end
      if (cfg.differential_time_setting == 16'h0000) begin
        next_dterm = '0;
      end else begin
        next_dterm = 48'(e - e_prev) *
          $signed({32'h0, cfg.differential_time_setting}) *
          48'(`PLA_TS_PER_HUNDREDTH);
      end
      // gain applies to the whole sum, as in the series-free form
      next_mv = (cfg.loop_mode_select == pla_pkg::PLA_OFF) ? 32'h0 :
        32'((prod / 64'(`PLA_GAIN_UNIT)) >>> `PLA_FRAC);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= 32'h0000_0000;
      fy <= '0;
      acc <= '0;
      dterm <= '0;
      e_prev <= '0;
      wind_q <= 1'b0;
      o_manipulated_frequency <= 32'h0000_0000;
    end else begin
      cnt <= next_cnt;
      fy <= next_fy;
      acc <= next_acc;
      dterm <= next_dterm;
      e_prev <= next_e_prev;
      wind_q <= next_wind_q;
      o_manipulated_frequency <= next_mv;
    end
  end

  // trip: bit 2 picks deviation, bit 0 hold, bit 1 latch
  assign cmdx = $signed({3'b000, cfg.process_command_value});
  assign lox = $signed({3'b000, cfg.lower_trip_bound_setting});
  assign hix = $signed({3'b000, cfg.upper_trip_bound_setting});
  assign fbw = 19'(fbf);
  assign in_trip = cfg.trip_kind_select[2] ?
    (fbw < cmdx - lox || fbw > cmdx + hix) :
    (fbw < lox || fbw > hix);
  assign raw = in_trip & (~cfg.trip_kind_select[0] | armed);
  assign trip = raw | latched;

  always_comb begin
    // only a leave seen while hold is chosen arms it, so the settings
    // written before the kind cannot arm the trip ahead of time
    next_armed = armed | (cfg.trip_kind_select[0] & ~in_trip);
    // a fresh trip wins over a clear in the same cycle
    next_latched = (latched & ~fclear) |
                   (raw & cfg.trip_kind_select[1]);
    next_trip_q = trip;
    next_out = trip ^ cfg.invert;
    next_stat = stat;
    if (wr && i_paddr == `PLA_OFS_STAT) begin
      next_stat = stat & ~i_pwdata[1:0];
    end
    if (trip & ~trip_q) begin
      next_stat[`PLA_ST_TRIP] = 1'b1;
    end
    if (tick & wind & ~wind_q) begin
      next_stat[`PLA_ST_WIND] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      armed <= 1'b0;
      latched <= 1'b0;
      trip_q <= 1'b0;
      stat <= 2'h0;
      o_loop_trip_output <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      armed <= next_armed;
      latched <= next_latched;
      trip_q <= next_trip_q;
      stat <= next_stat;
      o_loop_trip_output <= next_out;
      o_irq <= |(stat & mask);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_diff_zero: assert property (
    tick && cfg.differential_time_setting == 16'h0 |=> dterm == '0)
    else $error("d term not zero with zero time");
  chk_filter_bypass: assert property (
    tick && cfg.feedback_filter_time == 16'h0 |=> fy == $past(fbx))
    else $error("unfiltered feedback not taken");
  chk_windup_freeze: assert property (
    tick && wind && cfg.integral_time_setting != 16'h0 &&
    cfg.loop_mode_select != pla_pkg::PLA_OFF |=> $stable(acc))
    else $error("integrator moved outside band");
  chk_itime_zero: assert property (
    tick && cfg.integral_time_setting == 16'h0 |=> acc == '0)
    else $error("integrator live with zero time");
  chk_mode_off: assert property (
    tick && cfg.loop_mode_select == pla_pkg::PLA_OFF |=>
    o_manipulated_frequency == 32'h0)
    else $error("output not zero when off");
  chk_abs_trip: assert property (
    cfg.trip_kind_select == 3'h0 && !cfg.invert && fbw > hix
    |=> o_loop_trip_output)
    else $error("absolute trip missed");
  chk_dev_trip: assert property (
    cfg.trip_kind_select == 3'h4 && !cfg.invert && fbw < cmdx - lox
    |=> o_loop_trip_output)
    else $error("deviation trip missed");
  chk_hold_start: assert property (
    cfg.trip_kind_select[0] && !armed && !cfg.invert |=>
    !o_loop_trip_output)
    else $error("held trip fired before re-entry");
  chk_latch_keep: assert property (
    cfg.trip_kind_select[1] && latched && !fclear |=> latched)
    else $error("latched trip dropped");
  chk_inrange_inv: assert property (
    cfg.invert && !trip ##1 cfg.invert |-> o_loop_trip_output)
    else $error("inverted output not in-range");
  chk_gain_limit: assert property (
    cfg.proportional_gain_setting <= `PLA_MAX_GAIN &&
    cfg.windup_band_setting <= `PLA_MAX_BAND)
    else $error("setting beyond its limit");
  cov_latch: cover property (latched ##1 fclear ##1 !latched);
  cov_hold: cover property (!armed ##1 armed ##[1:200] raw);
  cov_windup: cover property (tick && wind);
  cov_inverse: cover property (
    cfg.loop_mode_select == pla_pkg::PLA_INVERSE && tick);
endmodule
`default_nettype wire

// ---- pla_sensor.sv ----
// feedback transducer model, answering promptly or slew-limited
`timescale 1ns/1ps
`default_nettype none
module pla_sensor (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic [15:0] i_target,
  output var logic [15:0] o_level = 16'h0000
);
  // a real transducer slews; 16 counts a clock keeps the run short
  always @(posedge i_clk) begin
    if (!i_slow || (o_level - i_target) < 16 || (i_target - o_level) < 16)
      o_level <= i_target;
    else if (o_level < i_target)
      o_level <= o_level + 16'h0010;
    else
      o_level <= o_level - 16'h0010;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the loop processor
`include "pla_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SC = 20;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd, o_manipulated_frequency;
  logic o_pready, o_pslverr, o_loop_trip_output, o_irq, err, inv;
  logic slow = 1'b0;
  logic [15:0] target = 16'h0000;
  logic [15:0] fb;
  logic signed [31:0] o1, o2;
  logic [2:0] k;
  int failures = 0, checks_done = 0, seed = 25323, up, lo, cmd, f, v;
  logic [7:0] ofs [5] = '{`PLA_OFS_GAIN, `PLA_OFS_ITIME, `PLA_OFS_DTIME,
    `PLA_OFS_FILT, `PLA_OFS_BAND};
  logic [15:0] lim [5] = '{`PLA_MAX_GAIN, `PLA_MAX_ITIME, `PLA_MAX_DTIME,
    `PLA_MAX_FILT, `PLA_MAX_BAND};
  initial forever #2.5 i_clk = ~i_clk;
  pla_sensor PART (.i_clk(i_clk), .i_slow(slow), .i_target(target),
    .o_level(fb));
  pla_loop #(.SAMPLE_CYC(SC)) DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_measured_feedback(fb),
    .o_manipulated_frequency(o_manipulated_frequency),
    .o_loop_trip_output(o_loop_trip_output), .o_irq(o_irq));
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(what, rd, e);
  endtask
  task automatic do_reset;
    @(posedge i_clk);
    i_rst <= 1'b1;
    target <= 16'h0000;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n * SC) @(posedge i_clk);
  endtask
  function automatic logic trip_of(input logic [2:0] kd,
                                   input int x, u, l, c);
    if (kd[2])
      return (x < c - l) || (x > c + u);
    return (x < l) || (x > u);
  endfunction
  initial begin
    repeat (60000) @(posedge i_clk);
    failures++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc("mode", `PLA_OFS_MODE, 32'h0);
    rdc("gain", `PLA_OFS_GAIN, 32'h3E8);
    rdc("upper", `PLA_OFS_UPPER, 32'h3E8);
    wr(`PLA_OFS_MODE, 32'h3);
    rdc("mode3", `PLA_OFS_MODE, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 32'hFFFF);
      rdc("limit", ofs[i], {16'h0, lim[i]});
    end
    apb(1'b0, 8'h3C, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    $display("registers done");
    do_reset;
    wr(`PLA_OFS_BAND, 32'h7D0);
    wr(`PLA_OFS_CMD, 32'h1F4);
    target <= 16'h012C;
    wr(`PLA_OFS_MODE, 32'h1);
    ticks(4);
    check("p", o_manipulated_frequency, 32'hC8);
    wr(`PLA_OFS_MODE, 32'h2);
    ticks(4);
    check("inv", o_manipulated_frequency, 32'hFFFFFF38);
    wr(`PLA_OFS_MODE, 32'h1);
    wr(`PLA_OFS_GAIN, 32'h7D0);
    ticks(4);
    check("gain", o_manipulated_frequency, 32'h190);
    wr(`PLA_OFS_GAIN, 32'h3E8);
    wr(`PLA_OFS_DTIME, 32'h64);
    target <= 16'h00C8;
    o1 = 0;
    repeat (4 * SC) begin
      @(posedge i_clk);
      if ($signed(o_manipulated_frequency) > o1)
        o1 = o_manipulated_frequency;
    end
    check("kick", o1, 32'(300 + 100 * 100 * `PLA_TS_PER_HUNDREDTH));
    ticks(2);
    check("settle", o_manipulated_frequency, 32'h12C);
    wr(`PLA_OFS_DTIME, 32'h0);
    wr(`PLA_OFS_ITIME, 32'h1);
    ticks(1);
    o1 = o_manipulated_frequency;
    ticks(10);
    o2 = o_manipulated_frequency;
    check("integ", {31'h0, o2 > o1}, 32'h1);
    wr(`PLA_OFS_BAND, 32'h64);
    ticks(2);
    o1 = o_manipulated_frequency;
    ticks(10);
    check("frozen", o_manipulated_frequency, o1);
    rdc("wstat", `PLA_OFS_STAT, 32'h2);
    wr(`PLA_OFS_MODE, 32'h0);
    ticks(2);
    check("off", o_manipulated_frequency, 32'h0);
    $display("loop done");
    // every trip kind; bounds go in before the kind, so a held kind
    // starts inside its trip range as it would at power-on
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      do_reset;
      up = k[2] ? 100 : 600;
      lo = k[2] ? 100 : 400;
      target <= 16'h0320;
      ticks(2);
      wr(`PLA_OFS_UPPER, 32'(up));
      wr(`PLA_OFS_LOWER, 32'(lo));
      wr(`PLA_OFS_CMD, 32'h1F4);
      wr(`PLA_OFS_KIND, {29'h0, k});
      wr(`PLA_OFS_STAT, 32'h1);
      wr(`PLA_OFS_MASK, 32'h1);
      repeat (2) @(posedge i_clk);
      check("trip", {31'h0, o_loop_trip_output},
        {31'h0, trip_of(k, 800, up, lo, 500) & ~k[0]});
      check("irq0", {31'h0, o_irq}, 32'h0);
      target <= 16'h01F4;
      ticks(3);
      check("latch", {31'h0, o_loop_trip_output}, {31'h0, k[1] & ~k[0]});
      target <= 16'h0320;
      ticks(3);
      check("rearm", {31'h0, o_loop_trip_output}, 32'h1);
      check("irq1", {31'h0, o_irq}, {31'h0, ~(k[1] & ~k[0])});
      target <= 16'h01F4;
      ticks(3);
      check("latch2", {31'h0, o_loop_trip_output}, {31'h0, k[1]});
      wr(`PLA_OFS_STAT, 32'h1);
      repeat (2) @(posedge i_clk);
      check("irqclr", {31'h0, o_irq}, 32'h0);
      wr(`PLA_OFS_CTRL, 32'h1);
      repeat (2) @(posedge i_clk);
      check("clear", {31'h0, o_loop_trip_output}, 32'h0);
    end
    $display("kinds done");
    do_reset;
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      k = {v[0], 2'b00};
      inv = v[1];
      slow <= v[2];
      up = $random(seed) & 255;
      lo = $random(seed) & 255;
      cmd = 200 + ($random(seed) & 511);
      f = $random(seed) & 1023;
      wr(`PLA_OFS_KIND, {29'h0, k});
      wr(`PLA_OFS_UPPER, 32'(up));
      wr(`PLA_OFS_LOWER, 32'(lo));
      wr(`PLA_OFS_CMD, 32'(cmd));
      wr(`PLA_OFS_CTRL, {30'h0, inv, 1'b0});
      target <= 16'(f);
      ticks(5);
      check("rand", {31'h0, o_loop_trip_output},
        {31'h0, trip_of(k, f, up, lo, cmd) ^ inv});
    end
    $display("random done");
    complete_run;
  end
endmodule
`default_nettype wire
